// File: rtl/ccr_core.sv
// cpu core datapath: alu, accumulator, carry, temp, pair, page, skip, context
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
module ccr_core (
  // clock and reset
  input  wire logic                         clk_sys_in,
  input  wire logic                         rst_in,
  // instruction issue from the decoder
  input  wire logic                         instr_valid_in,
  input  wire logic [4:0]                   op_in,
  input  wire logic [ccr_pkg::NIB_W-1:0]    imm_in,
  input  wire logic [1:0]                   bit_sel_in,
  input  wire logic [ccr_pkg::PCH_W-1:0]    page_in,
  input  wire logic [ccr_pkg::PC_W-1:0]     pc_in,
  // operands from memory, ports, rom and data pointer
  input  wire logic [ccr_pkg::NIB_W-1:0]    mem_data_in,
  input  wire logic [ccr_pkg::NIB_W-1:0]    port_data_in,
  input  wire logic [ccr_pkg::PAIR_W-1:0]   rom_data_in,
  input  wire logic [ccr_pkg::DP_W-1:0]     dp_in,
  // register port
  input  wire logic [ccr_pkg::RA_W-1:0]     reg_addr_in,
  input  wire logic [ccr_pkg::RD_W-1:0]     reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [ccr_pkg::RD_W-1:0]     reg_rdata_out,
  // datapath state
  output logic      [ccr_pkg::NIB_W-1:0]    acc_out,
  output logic                              carry_flag_out,
  output logic                              skip_flag_out,
  output logic      [ccr_pkg::NIB_W-1:0]    temp_out,
  output logic      [ccr_pkg::PAIR_W-1:0]   pair_out,
  output logic      [ccr_pkg::PAGE_W-1:0]   page_ptr_out,
  output logic      [ccr_pkg::SP_W-1:0]     level_out,
  // program counter and memory requests
  output logic                              mc_tick_out,
  output logic                              pc_load_out,
  output logic      [ccr_pkg::PC_W-1:0]     pc_target_out,
  output logic                              mem_we_out,
  output logic      [ccr_pkg::NIB_W-1:0]    mem_wdata_out,
  output logic                              dp_restore_out,
  output logic      [ccr_pkg::DP_W-1:0]     dp_restore_val_out
);
  ccr_stk_if stk ();

  ccr_stack u_stack (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .stk        (stk.stack)
  );

  // 4-bit add returning carry in the top bit
  function automatic logic [4:0] add4(input logic [3:0] a,
                                      input logic [3:0] b,
                                      input logic       ci);
    add4 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
  endfunction : add4

  // one-hot mask selecting a single bit of a nibble
  function automatic logic [3:0] bit_mask(input logic [1:0] sel);
    bit_mask = 4'h1 << sel;
  endfunction : bit_mask

  logic [1:0]                   mc_cnt;
  logic                         mc_tick;
  logic                         run;
  logic [ccr_pkg::NIB_W-1:0]    acc;
  logic                         carry;
  logic                         skip;
  logic [ccr_pkg::NIB_W-1:0]    temp;
  logic [ccr_pkg::PAIR_W-1:0]   pair;
  logic [ccr_pkg::PAGE_W-1:0]   page_ptr;
  logic [ccr_pkg::CTX_W-1:0]    ctx;
  logic                         exec;
  logic                         do_op;
  ccr_pkg::ccr_op_t             op;
  logic [4:0]                   sum;
  logic [ccr_pkg::NIB_W-1:0]    next_acc;
  logic                         next_carry;
  logic                         next_skip;
  logic [ccr_pkg::NIB_W-1:0]    next_temp;
  logic [ccr_pkg::PAIR_W-1:0]   next_pair;
  logic [ccr_pkg::PAGE_W-1:0]   next_page;
  logic                         next_pc_load;
  logic [ccr_pkg::PC_W-1:0]     next_pc_target;
  logic                         next_mem_we;
  logic [ccr_pkg::NIB_W-1:0]    next_mem_wdata;
  logic [ccr_pkg::PCL_W-1:0]    in_page_address;

  assign op = ccr_pkg::ccr_op_t'(op_in);

  // machine cycle: three system clocks; stopping run freezes the core
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mc_cnt  <= 2'h0;
      mc_tick <= 1'b0;
    end else if (run) begin
      mc_cnt  <= (mc_cnt == ccr_pkg::MC_LAST) ? 2'h0 : mc_cnt + 2'h1;
      mc_tick <= (mc_cnt == ccr_pkg::MC_LAST);
    end else begin
      mc_tick <= 1'b0;
    end
  end

  assign exec = mc_tick && instr_valid_in;
  // a pending skip swallows the instruction; interrupt entry is never
  // swallowed so the flag can be saved and restored across it
  assign do_op = exec && (!skip || op == ccr_pkg::OP_INT_ENTRY);

  assign in_page_address = {page_ptr, acc};
  assign sum = add4(acc, (op == ccr_pkg::OP_ADD_IMM) ? imm_in : mem_data_in,
                    (op == ccr_pkg::OP_ADD_MEM_C) ? carry : 1'b0);

  // stack requests
  always_comb begin
    stk.push    = 1'b0;
    stk.pop     = 1'b0;
    stk.push_pc = pc_in;
    if (do_op) begin
      case (op)
        ccr_pkg::OP_CALL, ccr_pkg::OP_IND_CALL,
        ccr_pkg::OP_TABLE_REF, ccr_pkg::OP_INT_ENTRY: begin
          stk.push = 1'b1;
        end
        ccr_pkg::OP_RET, ccr_pkg::OP_RETI, ccr_pkg::OP_TABLE_END: begin
          stk.pop = 1'b1;
        end
        default: begin
          stk.pop = 1'b0;
        end
      endcase
    end
  end

  // datapath next values
  always_comb begin
    next_acc       = acc;
    next_carry     = carry;
    next_skip      = skip;
    next_temp      = temp;
    next_pair      = pair;
    next_page      = page_ptr;
    next_pc_load   = 1'b0;
    next_pc_target = stk.top_pc;
    next_mem_we    = 1'b0;
    next_mem_wdata = mem_data_in;
    if (exec) begin
      next_skip = 1'b0;
    end
    if (do_op) begin
      case (op)
        ccr_pkg::OP_ADD_IMM: begin
          next_acc  = sum[3:0];
          next_skip = !sum[4];
        end
        ccr_pkg::OP_ADD_MEM: begin
          next_acc = sum[3:0];
        end
        ccr_pkg::OP_ADD_MEM_C: begin
          next_acc   = sum[3:0];
          next_carry = sum[4];
        end
        ccr_pkg::OP_AND_MEM: begin
          next_acc = acc & mem_data_in;
        end
        ccr_pkg::OP_OR_MEM: begin
          next_acc = acc | mem_data_in;
        end
        ccr_pkg::OP_CMP_MEM: begin
          next_skip = (acc == mem_data_in);
        end
        ccr_pkg::OP_CMP_IMM: begin
          next_skip = (acc == imm_in);
        end
        ccr_pkg::OP_SET_BIT: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = mem_data_in | bit_mask(bit_sel_in);
        end
        ccr_pkg::OP_CLR_BIT: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = mem_data_in & ~bit_mask(bit_sel_in);
        end
        ccr_pkg::OP_TEST_BIT: begin
          next_skip = ((mem_data_in & bit_mask(bit_sel_in)) == 4'h0);
        end
        ccr_pkg::OP_ROT_R: begin
          next_acc   = {carry, acc[3:1]};
          next_carry = acc[0];
        end
        ccr_pkg::OP_SET_C: begin
          next_carry = 1'b1;
        end
        ccr_pkg::OP_CLR_C: begin
          next_carry = 1'b0;
        end
        ccr_pkg::OP_SKIP_C: begin
          next_skip = carry;
        end
        ccr_pkg::OP_LOAD_IMM: begin
          next_acc = imm_in;
        end
        ccr_pkg::OP_LOAD_MEM: begin
          next_acc = mem_data_in;
        end
        ccr_pkg::OP_XCH_AT: begin
          next_acc  = temp;
          next_temp = acc;
        end
        ccr_pkg::OP_PAIR_PUT: begin
          next_pair = {temp, acc};
        end
        ccr_pkg::OP_PAIR_GET: begin
          next_temp = pair[7:4];
          next_acc  = pair[3:0];
        end
        ccr_pkg::OP_PAGE_LOAD: begin
          next_page = imm_in[2:0];
        end
        ccr_pkg::OP_PORT_IN: begin
          next_acc = port_data_in;
        end
        ccr_pkg::OP_LVL_TO_A: begin
          next_acc = {1'b0, stk.level};
        end
        ccr_pkg::OP_TABLE_REF, ccr_pkg::OP_IND_BR,
        ccr_pkg::OP_IND_CALL: begin
          next_pc_load   = 1'b1;
          next_pc_target = {page_in, in_page_address};
        end
        ccr_pkg::OP_TABLE_END: begin
          next_temp    = rom_data_in[7:4];
          next_acc     = rom_data_in[3:0];
          next_pc_load = 1'b1;
        end
        ccr_pkg::OP_RET: begin
          next_pc_load = 1'b1;
        end
        ccr_pkg::OP_RETI: begin
          next_pc_load = 1'b1;
          next_temp    = ctx[3:0];
          next_acc     = ctx[7:4];
          next_skip    = ctx[8];
          next_carry   = ctx[9];
        end
        default: begin
          next_pc_load = 1'b0;
        end
      endcase
    end
  end

  // accumulator and carry
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc   <= ccr_pkg::NIB_RST;
      carry <= 1'b0;
    end else begin
      acc   <= next_acc;
      carry <= next_carry;
    end
  end

  // skip flag
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      skip <= 1'b0;
    end else begin
      skip <= next_skip;
    end
  end

  // temp, pair and page pointer; pair and page get a value here only so
  // outputs are never unknown, software must still load them
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      temp     <= ccr_pkg::NIB_RST;
      pair     <= ccr_pkg::PAIR_RST;
      page_ptr <= ccr_pkg::PAGE_RST;
    end else begin
      temp     <= next_temp;
      pair     <= next_pair;
      page_ptr <= next_page;
    end
  end

  // single-stage interrupt context: only interrupt entry writes it
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctx <= '0;
    end else if (do_op && op == ccr_pkg::OP_INT_ENTRY) begin
      ctx <= {dp_in, carry, skip, acc, temp};
    end
  end

  // pc, memory and data pointer requests, one system clock pulses
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pc_load_out        <= 1'b0;
      pc_target_out      <= '0;
      mem_we_out         <= 1'b0;
      mem_wdata_out      <= ccr_pkg::NIB_RST;
      dp_restore_out     <= 1'b0;
      dp_restore_val_out <= '0;
    end else begin
      pc_load_out        <= next_pc_load;
      pc_target_out      <= next_pc_target;
      mem_we_out         <= next_mem_we;
      mem_wdata_out      <= next_mem_wdata;
      dp_restore_out     <= do_op && op == ccr_pkg::OP_RETI;
      dp_restore_val_out <= ctx[ccr_pkg::CTX_W-1:10];
    end
  end

  // state mirrors; one cycle behind the internal registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc_out        <= ccr_pkg::NIB_RST;
      carry_flag_out <= 1'b0;
      skip_flag_out  <= 1'b0;
      temp_out       <= ccr_pkg::NIB_RST;
      pair_out       <= ccr_pkg::PAIR_RST;
      page_ptr_out   <= ccr_pkg::PAGE_RST;
      level_out      <= ccr_pkg::SP_RST;
      mc_tick_out    <= 1'b0;
    end else begin
      acc_out        <= acc;
      carry_flag_out <= carry;
      skip_flag_out  <= skip;
      temp_out       <= temp;
      pair_out       <= pair;
      page_ptr_out   <= page_ptr;
      level_out      <= stk.level;
      mc_tick_out    <= mc_tick;
    end
  end

  // control register: run bit gates the machine cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      run <= ccr_pkg::CTRL_RUN_RST;
    end else if (reg_wr_in && reg_addr_in == ccr_pkg::ADDR_CTRL) begin
      run <= reg_wdata_in[ccr_pkg::CTRL_RUN_BIT];
    end
  end

  // read data valid only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ccr_pkg::ADDR_CTRL:  reg_rdata_out <= {7'h00, run};
        ccr_pkg::ADDR_FLAGS: reg_rdata_out <= {2'h0, skip, carry, acc};
        ccr_pkg::ADDR_TEMP:  reg_rdata_out <= {4'h0, temp};
        ccr_pkg::ADDR_PAIR:  reg_rdata_out <= pair;
        ccr_pkg::ADDR_PAGE:  reg_rdata_out <= {5'h00, page_ptr};
        ccr_pkg::ADDR_LEVEL: reg_rdata_out <= {5'h00, stk.level};
        default:             reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end
endmodule : ccr_core

// File: rtl/ccr_pkg.sv
// constants, opcodes and field layouts of the cpu core register datapath
// What this block does
// - alu adds, compares, ands, ors, manipulates bits
// - accumulator is 4-bit operand and result
// - add with carry sets carry on overflow
// - plain and immediate adds keep carry
// - rotate right moves accumulator bit0 into carry
// - set-carry forces one, clear-carry forces zero
// - temp register is upper half of transfers
// - pair high nibble temp, low nibble accumulator
// - pair and page pointer need software init
// - page pointer plus accumulator form in-page address
// - stack saves pc on interrupt, call, table
// - stack has eight identical entries
// - interrupt and table reference each use one entry
// - ninth push wraps, overwriting lowest entry
// - 3-bit pointer tracks level on push, pop
// - pointer-to-accumulator instruction copies stack level
// - interrupt entry saves dp, carry, skip, a, temp
// - calls and table reference leave context alone
// - skip flag decides skips, survives interrupts
// - pc is page part plus 7-bit offset
package ccr_pkg;
  localparam int NIB_W   = 4;
  localparam int PAIR_W  = 8;
  localparam int PAGE_W  = 3;
  localparam int PCL_W   = 7;
  localparam int PCH_W   = 5;
  localparam int PC_W    = PCH_W + PCL_W;
  localparam int DP_W    = 8;
  localparam int STK_N   = 8;
  localparam int SP_W    = 3;
  localparam int CTX_W   = DP_W + 2 + 2 * NIB_W;
  localparam int RA_W    = 3;
  localparam int RD_W    = 8;
  // last count of the machine cycle counter; the cycle is three system clocks
  localparam logic [1:0] MC_LAST = 2'h2;
  // register port offsets
  localparam logic [RA_W-1:0] ADDR_CTRL  = 3'h0;
  localparam logic [RA_W-1:0] ADDR_FLAGS = 3'h1;
  localparam logic [RA_W-1:0] ADDR_TEMP  = 3'h2;
  localparam logic [RA_W-1:0] ADDR_PAIR  = 3'h3;
  localparam logic [RA_W-1:0] ADDR_PAGE  = 3'h4;
  localparam logic [RA_W-1:0] ADDR_LEVEL = 3'h5;
  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int FLG_CARRY    = 4;
  localparam int FLG_SKIP     = 5;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
  localparam logic [PAIR_W-1:0] PAIR_RST = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 3'h0;
  localparam logic [SP_W-1:0] SP_RST = 3'h0;

  typedef enum logic [4:0] {
    OP_NOP       = 5'h00,
    OP_ADD_IMM   = 5'h01,
    OP_ADD_MEM   = 5'h02,
    OP_ADD_MEM_C = 5'h03,
    OP_AND_MEM   = 5'h04,
    OP_OR_MEM    = 5'h05,
    OP_CMP_MEM   = 5'h06,
    OP_CMP_IMM   = 5'h07,
    OP_SET_BIT   = 5'h08,
    OP_CLR_BIT   = 5'h09,
    OP_TEST_BIT  = 5'h0A,
    OP_ROT_R     = 5'h0B,
    OP_SET_C     = 5'h0C,
    OP_CLR_C     = 5'h0D,
    OP_SKIP_C    = 5'h0E,
    OP_LOAD_IMM  = 5'h0F,
    OP_LOAD_MEM  = 5'h10,
    OP_XCH_AT    = 5'h11,
    OP_PAIR_PUT  = 5'h12,
    OP_PAIR_GET  = 5'h13,
    OP_PAGE_LOAD = 5'h14,
    OP_PORT_IN   = 5'h15,
    OP_LVL_TO_A  = 5'h16,
    OP_CALL      = 5'h17,
    OP_TABLE_REF = 5'h18,
    OP_TABLE_END = 5'h19,
    OP_IND_BR    = 5'h1A,
    OP_IND_CALL  = 5'h1B,
    OP_RET       = 5'h1C,
    OP_RETI      = 5'h1D,
    OP_INT_ENTRY = 5'h1E
  } ccr_op_t;
endpackage : ccr_pkg

// File: rtl/ccr_stack.sv
// eight-entry wrapping return-address stack with its level pointer
`timescale 1ns/100ps
module ccr_stack (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // core side
  ccr_stk_if.stack  stk
);
  logic [ccr_pkg::PC_W-1:0] entry [ccr_pkg::STK_N];
  logic [ccr_pkg::SP_W-1:0] level;

  // entries are data only; no reset keeps them cheap
  always_ff @(posedge clk_sys_in) begin
    if (stk.push) begin
      entry[level] <= stk.push_pc;
    end
  end

  // pointer wraps at eight so a ninth push lands on entry zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      level <= ccr_pkg::SP_RST;
    end else if (stk.push) begin
      level <= level + 3'h1;
    end else if (stk.pop) begin
      level <= level - 3'h1;
    end
  end

  assign stk.top_pc = entry[level - 3'h1];
  assign stk.level  = level;
endmodule : ccr_stack

// File: rtl/ccr_stk_if.sv
// push and pop channel between the core and its return-address stack
`timescale 1ns/100ps
interface ccr_stk_if;
  logic                        push;
  logic                        pop;
  logic [ccr_pkg::PC_W-1:0]    push_pc;
  logic [ccr_pkg::PC_W-1:0]    top_pc;
  logic [ccr_pkg::SP_W-1:0]    level;
  modport core  (output push, output pop, output push_pc,
                 input top_pc, input level);
  modport stack (input push, input pop, input push_pc,
                 output top_pc, output level);
endinterface : ccr_stk_if

// File: verif/ccr_core_asserts.sv
// concurrent checks on the core datapath ports
`timescale 1ns/100ps
module ccr_core_asserts (
  // clock and reset
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  // instruction issue
  input wire logic       instr_valid_in,
  input wire logic [4:0] op_in,
  // datapath state
  input wire logic [3:0] acc_out,
  input wire logic       carry_flag_out,
  input wire logic       skip_flag_out,
  input wire logic [3:0] temp_out,
  input wire logic [7:0] pair_out,
  input wire logic [2:0] level_out,
  // machine tick and program counter load
  input wire logic       mc_tick_out,
  input wire logic       pc_load_out
);
  logic [4:0] op_q;
  logic       ex_q;
  logic       fire;
  logic       push;
  logic       pop;
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // op seen one edge before the tick mirror; skipped ops are left out
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      op_q <= 5'h00;
      ex_q <= 1'b0;
    end else begin
      op_q <= op_in;
      // interrupt entry runs even with a pending skip
      ex_q <= instr_valid_in & (~skip_flag_out |
        op_in == ccr_pkg::OP_INT_ENTRY);
    end
  end
  assign fire = mc_tick_out & ex_q;
  assign push = fire & (op_q == ccr_pkg::OP_CALL ||
    op_q == ccr_pkg::OP_IND_CALL || op_q == ccr_pkg::OP_TABLE_REF ||
    op_q == ccr_pkg::OP_INT_ENTRY);
  assign pop = fire & (op_q == ccr_pkg::OP_RET ||
    op_q == ccr_pkg::OP_RETI || op_q == ccr_pkg::OP_TABLE_END);

  a_tick_spacing: assert property (
    mc_tick_out |=> !mc_tick_out [*2]) else $error("tick too close");
  a_mirror_hold: assert property (
    !$past(mc_tick_out) && !$past(rst_in) |-> $stable({acc_out,
    carry_flag_out, skip_flag_out, temp_out, pair_out, level_out}))
    else $error("state changed off the machine cycle");
  a_set_carry: assert property (
    fire && op_q == ccr_pkg::OP_SET_C |=> carry_flag_out)
    else $error("set carry failed");
  a_clr_carry: assert property (
    fire && op_q == ccr_pkg::OP_CLR_C |=> !carry_flag_out)
    else $error("clear carry failed");
  a_add_keeps_carry: assert property (
    fire && (op_q == ccr_pkg::OP_ADD_IMM || op_q == ccr_pkg::OP_ADD_MEM)
    |=> $stable(carry_flag_out)) else $error("plain add moved carry");
  a_rot_through_carry: assert property (
    fire && op_q == ccr_pkg::OP_ROT_R |=> {acc_out, carry_flag_out} ==
    {$past(carry_flag_out), $past(acc_out)}) else $error("rotate wrong");
  a_pair_put: assert property (
    fire && op_q == ccr_pkg::OP_PAIR_PUT |=> pair_out ==
    {$past(temp_out), $past(acc_out)}) else $error("pair order wrong");
  a_level_to_acc: assert property (
    fire && op_q == ccr_pkg::OP_LVL_TO_A |=> acc_out ==
    {1'b0, $past(level_out)}) else $error("level copy wrong");
  a_push_level: assert property (
    push |=> level_out == $past(level_out) + 3'h1)
    else $error("push did not step level");
  a_pop_level: assert property (
    pop |-> pc_load_out ##1 level_out == $past(level_out) - 3'h1)
    else $error("pop did not load pc or step level");
endmodule : ccr_core_asserts

bind ccr_core ccr_core_asserts u_chk (.clk_sys_in, .rst_in,
  .instr_valid_in, .op_in, .acc_out, .carry_flag_out, .skip_flag_out,
  .temp_out, .pair_out, .level_out, .mc_tick_out, .pc_load_out);

// File: verif/test_ccr_core.sv
// self-checking bench driving the core datapath instruction and register ports
`timescale 1ns/100ps
module test_ccr_core;
  logic        clk_sys_in, rst_in, instr_valid_in, reg_wr_in, reg_rd_in;
  logic        carry_flag_out, skip_flag_out, mc_tick_out, pc_load_out;
  logic        mem_we_out, dp_restore_out, pl, dr, mw;
  logic [1:0]  bit_sel_in;
  logic [2:0]  reg_addr_in, page_ptr_out, level_out;
  logic [3:0]  imm_in, mem_data_in, port_data_in, acc_out, temp_out;
  logic [3:0]  mem_wdata_out, mwd;
  logic [4:0]  op_in, page_in;
  logic [7:0]  rom_data_in, dp_in, reg_wdata_in, reg_rdata_out, pair_out;
  logic [7:0]  dp_restore_val_out, drv;
  logic [11:0] pc_in, pc_target_out, pt, n;
  int          err_total, checks, cyc;

  ccr_core dut (.clk_sys_in, .rst_in, .instr_valid_in, .op_in, .imm_in,
    .bit_sel_in, .page_in, .pc_in, .mem_data_in, .port_data_in,
    .rom_data_in, .dp_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .acc_out, .carry_flag_out, .skip_flag_out,
    .temp_out, .pair_out, .page_ptr_out, .level_out, .mc_tick_out,
    .pc_load_out, .pc_target_out, .mem_we_out, .mem_wdata_out,
    .dp_restore_out, .dp_restore_val_out);

  task automatic end_sim();
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cs(input logic [3:0] a, input logic c, input logic s,
                    input logic [3:0] t);
    chk({2'h0, acc_out, carry_flag_out, skip_flag_out, temp_out},
        {2'h0, a, c, s, t});
  endtask : cs

  // resync to a tick first, since register accesses break the cadence
  task automatic exec(input ccr_pkg::ccr_op_t o, input logic [3:0] im,
                      input logic [3:0] md);
    do @(posedge clk_sys_in); while (mc_tick_out !== 1'b1);
    instr_valid_in <= 1'b1;
    op_in          <= o;
    imm_in         <= im;
    mem_data_in    <= md;
    do @(posedge clk_sys_in); while (mc_tick_out !== 1'b1);
    pl = pc_load_out;
    pt = pc_target_out;
    dr = dp_restore_out;
    mw = mem_we_out;
    mwd = mem_wdata_out;
    drv = dp_restore_val_out;
    instr_valid_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : exec

  task automatic pop_chk(input ccr_pkg::ccr_op_t o, input logic [11:0] e,
                         input logic [2:0] l);
    exec(o, 4'h0, 4'h0);
    chk(pt, e);
    chk({8'h00, pl, level_out}, {8'h00, 1'b1, l});
  endtask : pop_chk

  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
    @(posedge clk_sys_in);
    chk({4'h0, reg_rdata_out}, {4'h0, e});
  endtask : rchk

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
  endtask : wreg

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    {rst_in, instr_valid_in, reg_wr_in, reg_rd_in} = 4'h8;
    {op_in, imm_in, bit_sel_in, page_in, mem_data_in} = 20'h00000;
    {port_data_in, rom_data_in, dp_in, pc_in} = 32'h0;
    {reg_addr_in, reg_wdata_in} = 11'h000;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    cs(4'h0, 1'b0, 1'b0, 4'h0);
    rchk(ccr_pkg::ADDR_CTRL, 8'h01);
    rchk(3'h7, 8'h00);
    exec(ccr_pkg::OP_LOAD_IMM, 4'h9, 4'h0);
    exec(ccr_pkg::OP_CLR_C, 4'h0, 4'h0);
    exec(ccr_pkg::OP_ADD_MEM_C, 4'h0, 4'h8);
    cs(4'h1, 1'b1, 1'b0, 4'h0);
    exec(ccr_pkg::OP_ADD_MEM, 4'h0, 4'hF);
    cs(4'h0, 1'b1, 1'b0, 4'h0);
    exec(ccr_pkg::OP_ADD_IMM, 4'h3, 4'h0);
    cs(4'h3, 1'b1, 1'b1, 4'h0);
    exec(ccr_pkg::OP_LOAD_IMM, 4'h5, 4'h0);
    cs(4'h3, 1'b1, 1'b0, 4'h0);
    exec(ccr_pkg::OP_ADD_IMM, 4'hF, 4'h0);
    cs(4'h2, 1'b1, 1'b0, 4'h0);
    exec(ccr_pkg::OP_LOAD_IMM, 4'hC, 4'h0);
    exec(ccr_pkg::OP_AND_MEM, 4'h0, 4'hA);
    exec(ccr_pkg::OP_OR_MEM, 4'h0, 4'h3);
    exec(ccr_pkg::OP_CMP_IMM, 4'hB, 4'h0);
    cs(4'hB, 1'b1, 1'b1, 4'h0);
    exec(ccr_pkg::OP_NOP, 4'h0, 4'h0);
    exec(ccr_pkg::OP_CMP_MEM, 4'h0, 4'h4);
    cs(4'hB, 1'b1, 1'b0, 4'h0);
    exec(ccr_pkg::OP_CLR_C, 4'h0, 4'h0);
    cs(4'hB, 1'b0, 1'b0, 4'h0);
    exec(ccr_pkg::OP_SET_C, 4'h0, 4'h0);
    cs(4'hB, 1'b1, 1'b0, 4'h0);
    exec(ccr_pkg::OP_LOAD_IMM, 4'h5, 4'h0);
    exec(ccr_pkg::OP_CLR_C, 4'h0, 4'h0);
    exec(ccr_pkg::OP_ROT_R, 4'h0, 4'h0);
    cs(4'h2, 1'b1, 1'b0, 4'h0);
    exec(ccr_pkg::OP_ROT_R, 4'h0, 4'h0);
    cs(4'h9, 1'b0, 1'b0, 4'h0);
    exec(ccr_pkg::OP_LOAD_IMM, 4'h3, 4'h0);
    exec(ccr_pkg::OP_XCH_AT, 4'h0, 4'h0);
    cs(4'h0, 1'b0, 1'b0, 4'h3);
    exec(ccr_pkg::OP_LOAD_IMM, 4'hA, 4'h0);
    exec(ccr_pkg::OP_PAIR_PUT, 4'h0, 4'h0);
    chk({4'h0, pair_out}, 12'h03A);
    exec(ccr_pkg::OP_LOAD_IMM, 4'h0, 4'h0);
    exec(ccr_pkg::OP_XCH_AT, 4'h0, 4'h0);
    exec(ccr_pkg::OP_PAIR_GET, 4'h0, 4'h0);
    cs(4'hA, 1'b0, 1'b0, 4'h3);
    rchk(ccr_pkg::ADDR_PAIR, 8'h3A);
    port_data_in <= 4'h6;
    exec(ccr_pkg::OP_PORT_IN, 4'h0, 4'h0);
    cs(4'h6, 1'b0, 1'b0, 4'h3);
    bit_sel_in <= 2'h2;
    exec(ccr_pkg::OP_SET_BIT, 4'h0, 4'h1);
    chk({7'h00, mw, mwd}, 12'h015);
    exec(ccr_pkg::OP_CLR_BIT, 4'h0, 4'hF);
    chk({7'h00, mw, mwd}, 12'h01B);
    // bit two of the operand is clear, so the next load is swallowed
    exec(ccr_pkg::OP_TEST_BIT, 4'h0, 4'hB);
    exec(ccr_pkg::OP_LOAD_MEM, 4'h0, 4'h2);
    cs(4'h6, 1'b0, 1'b0, 4'h3);
    exec(ccr_pkg::OP_LOAD_MEM, 4'h0, 4'h2);
    cs(4'h2, 1'b0, 1'b0, 4'h3);
    exec(ccr_pkg::OP_PAGE_LOAD, 4'h6, 4'h0);
    exec(ccr_pkg::OP_LOAD_IMM, 4'h9, 4'h0);
    page_in <= 5'h05;
    exec(ccr_pkg::OP_IND_BR, 4'h0, 4'h0);
    chk({pl, pt[10:0]}, {1'b1, 4'h5, 3'h6, 4'h9});
    chk({8'h00, pt[11], page_ptr_out}, 12'h006);
    // nine pushes: the ninth lands on the lowest entry
    for (int i = 0; i < 9; i++) begin
      pc_in <= 12'h100 + 12'(i);
      exec(i == 8 ? ccr_pkg::OP_IND_CALL : ccr_pkg::OP_CALL,
           4'h0, 4'h0);
    end
    chk({pl, pt[10:0]}, {1'b1, 4'h5, 3'h6, 4'h9});
    exec(ccr_pkg::OP_LVL_TO_A, 4'h0, 4'h0);
    cs(4'h1, 1'b0, 1'b0, 4'h3);
    pop_chk(ccr_pkg::OP_RET, 12'h108, 3'h0);
    pop_chk(ccr_pkg::OP_RET, 12'h107, 3'h7);
    for (int k = 6; k > 0; k--) begin
      pop_chk(ccr_pkg::OP_RET, 12'h100 + 12'(k), 3'(k));
    end
    pop_chk(ccr_pkg::OP_RET, 12'h108, 3'h0);
    pc_in <= 12'h2AB;
    exec(ccr_pkg::OP_TABLE_REF, 4'h0, 4'h0);
    rom_data_in <= 8'hC4;
    pop_chk(ccr_pkg::OP_TABLE_END, 12'h2AB, 3'h0);
    cs(4'h4, 1'b0, 1'b0, 4'hC);
    exec(ccr_pkg::OP_LOAD_IMM, 4'h3, 4'h0);
    exec(ccr_pkg::OP_XCH_AT, 4'h0, 4'h0);
    exec(ccr_pkg::OP_SET_C, 4'h0, 4'h0);
    exec(ccr_pkg::OP_ADD_IMM, 4'h0, 4'h0);
    cs(4'hC, 1'b1, 1'b1, 4'h3);
    dp_in <= 8'h5C;
    pc_in <= 12'h0A1;
    exec(ccr_pkg::OP_INT_ENTRY, 4'h0, 4'h0);
    exec(ccr_pkg::OP_LOAD_IMM, 4'h1, 4'h0);
    exec(ccr_pkg::OP_CLR_C, 4'h0, 4'h0);
    exec(ccr_pkg::OP_XCH_AT, 4'h0, 4'h0);
    pc_in <= 12'h3F0;
    exec(ccr_pkg::OP_CALL, 4'h0, 4'h0);
    exec(ccr_pkg::OP_TABLE_REF, 4'h0, 4'h0);
    rom_data_in <= 8'h00;
    pop_chk(ccr_pkg::OP_TABLE_END, 12'h3F0, 3'h2);
    pop_chk(ccr_pkg::OP_RET, 12'h3F0, 3'h1);
    pop_chk(ccr_pkg::OP_RETI, 12'h0A1, 3'h0);
    chk({3'h0, dr, drv}, {3'h0, 1'b1, 8'h5C});
    cs(4'hC, 1'b1, 1'b1, 4'h3);
    rchk(ccr_pkg::ADDR_FLAGS, 8'h3C);
    rchk(ccr_pkg::ADDR_PAGE, 8'h06);
    rchk(ccr_pkg::ADDR_LEVEL, 8'h00);
    wreg(ccr_pkg::ADDR_TEMP, 8'hFF);
    rchk(ccr_pkg::ADDR_TEMP, 8'h03);
    // a stopped machine cycle must freeze all instruction issue
    wreg(ccr_pkg::ADDR_CTRL, 8'h00);
    repeat (4) @(posedge clk_sys_in);
    n = 12'h000;
    repeat (9) begin
      @(posedge clk_sys_in);
      if (mc_tick_out !== 1'b0) n = n + 12'h001;
    end
    chk(n, 12'h000);
    rchk(ccr_pkg::ADDR_CTRL, 8'h00);
    wreg(ccr_pkg::ADDR_CTRL, 8'h01);
    exec(ccr_pkg::OP_NOP, 4'h0, 4'h0);
    cs(4'hC, 1'b1, 1'b0, 4'h3);
    exec(ccr_pkg::OP_SKIP_C, 4'h0, 4'h0);
    cs(4'hC, 1'b1, 1'b1, 4'h3);
    end_sim();
  end
endmodule : test_ccr_core
